/* File: hw/fsop_port.sv */
// Failsafe six-channel output port
module fsop_port #(
    parameter int CH = fsop_pkg::CH_COUNT,
    parameter int DELAY_CYC = fsop_pkg::APPLY_DELAY_CYC,
    parameter int LOSS_CYC = fsop_pkg::LOSS_CYCLES * fsop_pkg::MIN_CYCLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cycle_sync_event,
    input wire logic frame_valid,
    input wire logic [7:0] frame_switch_pattern,
    input wire logic [7:0] frame_failsafe_release,
    input wire logic acyc_wr,
    input wire logic acyc_rd,
    input wire logic [7:0] acyc_addr,
    input wire logic [7:0] acyc_wdata,
    output logic [7:0] acyc_rdata,
    output logic [7:0] output_fault_status,
    input wire logic [CH-1:0] chan_sense,
    input wire logic [CH-1:0] chan_overload,
    input wire logic io_supply_ok,
    output logic [CH-1:0] chan_drive,
    output logic error_event,
    output logic module_healthy_flag,
    output logic [1:0] logical_slots
);
    import fsop_pkg::*;
    typedef enum logic [0:0] {FSOP_NORMAL, FSOP_FAILSAFE} fsop_mode_t;
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [CH-1:0] sense_s1_reg, sense_reg;
    logic [CH-1:0] ovl_s1_reg, ovl_reg;
    logic sup_s1_reg, sup_reg;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sense_s1_reg <= '0;
            sense_reg <= '0;
            ovl_s1_reg <= '0;
            ovl_reg <= '0;
            sup_s1_reg <= 1'b0;
            sup_reg <= 1'b0;
        end
        else
        begin
            sense_s1_reg <= chan_sense;
            sense_reg <= sense_s1_reg;
            ovl_s1_reg <= chan_overload;
            ovl_reg <= ovl_s1_reg;
            sup_s1_reg <= io_supply_ok;
            sup_reg <= sup_s1_reg;
        end
    end
    // ----------------------------------------
    // Frame capture and loss watchdog
    // ----------------------------------------
    logic [CH-1:0] pattern_reg;
    logic [31:0] loss_cnt_reg;
    logic loss_event;
    logic release_reg;
    fsop_mode_t mode_reg;
    assign loss_event = (loss_cnt_reg == 32'(LOSS_CYC - 1)) && !frame_valid;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pattern_reg <= PATTERN_RESET;
        else if (frame_valid)
            pattern_reg <= frame_switch_pattern[CH-1:0];
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            loss_cnt_reg <= '0;
        else if (frame_valid)
            loss_cnt_reg <= '0;
        else if (loss_cnt_reg != 32'(LOSS_CYC - 1))
            loss_cnt_reg <= loss_cnt_reg + 32'd1;
    end

    // Release copy starts cleared: failsafe after initial start
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            release_reg <= 1'b0;
        else if (frame_valid)
            release_reg <= frame_failsafe_release[RELEASE_BIT];
        else if (loss_event)
            release_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            mode_reg <= FSOP_FAILSAFE;
        else
        begin
            case (mode_reg)
                FSOP_NORMAL:
                    if (!release_reg)
                        mode_reg <= FSOP_FAILSAFE;
                FSOP_FAILSAFE:
                    if (release_reg)
                        mode_reg <= FSOP_NORMAL;
                default:
                    mode_reg <= FSOP_FAILSAFE;
            endcase
        end
    end
    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [7:0] mode_sel_reg;
    logic [7:0] static_reg;
    logic [7:0] static_pend_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            mode_sel_reg <= MODE_RESET;
        else if (acyc_wr && acyc_addr == REG_MODE_SELECT)
            mode_sel_reg <= acyc_wdata;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            static_pend_reg <= STATIC_RESET;
        else if (acyc_wr && acyc_addr == REG_STATIC_PATTERN)
            static_pend_reg <= acyc_wdata;
    end

    // Written value only takes effect once release copy is set
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            static_reg <= STATIC_RESET;
        else if (release_reg)
            static_reg <= static_pend_reg;
    end

    // ----------------------------------------
    // Output apply delay after sync
    // ----------------------------------------
    logic [15:0] dly_cnt_reg;
    logic dly_run_reg;
    logic apply_pulse;
    logic [CH-1:0] target;
    logic [CH-1:0] last_valid_reg;
    assign apply_pulse = dly_run_reg && (dly_cnt_reg == 16'(DELAY_CYC - 1));
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dly_run_reg <= 1'b0;
            dly_cnt_reg <= '0;
        end
        else if (cycle_sync_event)
        begin
            dly_run_reg <= 1'b1;
            dly_cnt_reg <= '0;
        end
        else if (apply_pulse)
            dly_run_reg <= 1'b0;
        else if (dly_run_reg)
            dly_cnt_reg <= dly_cnt_reg + 16'd1;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            last_valid_reg <= PATTERN_RESET;
        else if (apply_pulse && mode_reg == FSOP_NORMAL)
            last_valid_reg <= pattern_reg;
    end
    always_comb
    begin
        if (mode_reg == FSOP_NORMAL)
            target = pattern_reg;
        else if (mode_sel_reg == MODE_RETAIN)
            target = last_valid_reg;
        else
            target = static_reg[CH-1:0];
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            chan_drive <= '0;
        else if (apply_pulse)
            chan_drive <= target;
    end
    // ----------------------------------------
    // Channel monitoring
    // ----------------------------------------
    logic [CH-1:0] fault_reg;
    logic [CH-1:0] drive_d_reg, drive_d2_reg;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            {drive_d2_reg, drive_d_reg} <= '0;
        else
            {drive_d2_reg, drive_d_reg} <= {drive_d_reg, chan_drive};
    end
    genvar g;
    generate
        for (g = 0; g < CH; g++)
        begin : g_mon
            // Blank two cycles so the sense synchroniser catches up
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    fault_reg[g] <= 1'b0;
                else if ((chan_drive[g] != drive_d_reg[g]) || (drive_d_reg[g] != drive_d2_reg[g]))
                    fault_reg[g] <= 1'b0;
                else
                    fault_reg[g] <= ovl_reg[g]
                        || (chan_drive[g] && !sup_reg)
                        || (!chan_drive[g] && sense_reg[g])
                        || (chan_drive[g] && !sense_reg[g]);
            end
        end
    endgenerate
    logic [CH-1:0] fault_d_reg;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            fault_d_reg <= '0;
            error_event <= 1'b0;
        end
        else
        begin
            fault_d_reg <= fault_reg;
            error_event <= (fault_reg != fault_d_reg);
        end
    end
    assign output_fault_status = {{(8 - CH){1'b0}}, fault_reg};
    assign module_healthy_flag = (mode_reg == FSOP_NORMAL);
    assign logical_slots = 2'(LOGICAL_SLOTS);
    // ----------------------------------------
    // Acyclic read port
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            acyc_rdata <= 8'h00;
        else if (acyc_rd)
        begin
            if (acyc_addr == REG_FAULT_STATUS)
                acyc_rdata <= output_fault_status;
            else if (acyc_addr == REG_MODE_SELECT)
                acyc_rdata <= mode_sel_reg;
            else if (acyc_addr == REG_STATIC_PATTERN)
                acyc_rdata <= static_reg;
            else if (acyc_addr == REG_RELEASE)
                acyc_rdata <= {7'h00, release_reg};
            else
                acyc_rdata <= 8'h00;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_enter_failsafe;
        !release_reg ##1 !module_healthy_flag;
    endsequence
    property p_apply_bound;
        @(posedge ref_clk) disable iff (rst)
        cycle_sync_event |-> ##[1:DELAY_CYC] (apply_pulse || cycle_sync_event);
    endproperty
    a_apply_bound: assert property (p_apply_bound) else $error("apply late");
    property p_normal_drive;
        @(posedge ref_clk) disable iff (rst)
        apply_pulse && mode_reg == FSOP_NORMAL |=> chan_drive == $past(pattern_reg);
    endproperty
    a_normal_drive: assert property (p_normal_drive) else $error("normal drive");
    property p_static_drive;
        @(posedge ref_clk) disable iff (rst)
        apply_pulse && mode_reg == FSOP_FAILSAFE && mode_sel_reg == MODE_STATIC
        |=> chan_drive == $past(static_reg[CH-1:0]);
    endproperty
    a_static_drive: assert property (p_static_drive) else $error("static drive");
    property p_loss_clears;
        @(posedge ref_clk) disable iff (rst)
        loss_event |=> s_enter_failsafe;
    endproperty
    a_loss_clears: assert property (p_loss_clears) else $error("loss not failsafe");
    property p_resume;
        @(posedge ref_clk) disable iff (rst)
        frame_valid && frame_failsafe_release[0] |=> ##1 module_healthy_flag;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_static_hold;
        @(posedge ref_clk) disable iff (rst)
        !release_reg |=> static_reg == $past(static_reg);
    endproperty
    a_static_hold: assert property (p_static_hold) else $error("static taken");
    property p_error_evt;
        @(posedge ref_clk) disable iff (rst)
        fault_reg != fault_d_reg |=> error_event;
    endproperty
    a_error_evt: assert property (p_error_evt) else $error("no error event");
    property p_restart;
        @(posedge ref_clk) disable iff (rst)
        chan_drive != drive_d_reg |=> (fault_reg & ($past(chan_drive) ^ $past(drive_d_reg))) == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("monitor not reset");
    property p_healthy;
        @(posedge ref_clk) disable iff (rst)
        $rose(module_healthy_flag) |-> $past(release_reg);
    endproperty
    a_healthy: assert property (p_healthy) else $error("healthy flag");
endmodule : fsop_port

/* File: common/fsop_pkg.sv */
// Package of constants for the failsafe output port
package fsop_pkg;
    localparam int CLK_MHZ = 50;
    localparam int CH_COUNT = 6;
    // Output apply delay, longest time in ns
    localparam int APPLY_DELAY_MAX_NS = 60000;
    localparam int APPLY_DELAY_NS = 10000;
    localparam int APPLY_DELAY_CYC = (APPLY_DELAY_NS * CLK_MHZ) / 1000;
    // Least bus cycle time in ns
    localparam int MIN_CYCLE_NS = 100000;
    localparam int MIN_CYCLE_CYC = (MIN_CYCLE_NS * CLK_MHZ + 999) / 1000;
    // Cycles without refresh before a failsafe event
    localparam int LOSS_CYCLES = 3;
    // Register numbers; all but REG_SWITCH_PATTERN are used for acyclic access
    localparam logic [7:0] REG_SWITCH_PATTERN = 8'h02;
    localparam logic [7:0] REG_FAULT_STATUS = 8'h1E;
    localparam logic [7:0] REG_MODE_SELECT = 8'h20;
    localparam logic [7:0] REG_RELEASE = 8'h22;
    localparam logic [7:0] REG_STATIC_PATTERN = 8'h24;
    localparam int RELEASE_BIT = 0;
    localparam logic [7:0] MODE_STATIC = 8'h00;
    localparam logic [7:0] MODE_RETAIN = 8'h01;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] STATIC_RESET = 8'h00;
    localparam logic [5:0] PATTERN_RESET = 6'h00;
    localparam int LOGICAL_SLOTS = 1;
    // Identity code, value arbitrary
    localparam logic [15:0] MODULE_ID = 16'h0A5C;
endpackage : fsop_pkg

/* File: tb/fsop_master_model.sv */
// Master controller model sending cyclic frames and sync events
module fsop_master_model #(
    parameter int CYC = fsop_pkg::MIN_CYCLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic frames_on,
    input wire logic release_bit,
    input wire logic [7:0] pattern,
    output logic cycle_sync_event,
    output logic frame_valid,
    output logic [7:0] frame_switch_pattern,
    output logic [7:0] frame_failsafe_release
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 0;
            cycle_sync_event <= 1'b0;
            frame_valid <= 1'b0;
            frame_switch_pattern <= 8'h00;
            frame_failsafe_release <= 8'h00;
        end
        else
        begin
            cnt <= (cnt == CYC - 1) ? 0 : cnt + 1;
            cycle_sync_event <= (cnt == 1);
            frame_valid <= frames_on && (cnt == 0);
            if (frames_on && (cnt == 0))
            begin
                frame_switch_pattern <= pattern;
                frame_failsafe_release <= {7'h00, release_bit};
            end
            else
            begin
                // Stale data lines never repeat the last value
                frame_switch_pattern <= ~frame_switch_pattern;
                frame_failsafe_release <= ~frame_failsafe_release;
            end
        end
    end
endmodule : fsop_master_model

/* File: tb/fsop_port_bench.sv */
// Testbench for the failsafe output port
module fsop_port_bench;
    import fsop_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, frames_on, release_bit, sync, fv, acyc_wr, acyc_rd, io_supply_ok;
    logic [7:0] pattern, fsp, ffr, acyc_addr, acyc_wdata, acyc_rdata, output_fault_status;
    logic [5:0] chan_sense, chan_overload, chan_drive, sense_flip;
    logic error_event, module_healthy_flag;
    logic [1:0] logical_slots;
    int n_errors = 0;
    int tests_run = 0;
    int n_ev = 0;
    logic [7:0] tbl [3][4] = '{'{8'h08, 8'h00, 8'h01, 8'h08}, '{8'h00, 8'h00, 8'h00, 8'h15},
                               '{8'h00, 8'h02, 8'h01, 8'h02}};
    assign chan_sense = chan_drive ^ sense_flip;
    fsop_master_model #(.CYC(10)) u_master (.ref_clk(ref_clk), .rst(rst),
        .frames_on(frames_on), .release_bit(release_bit), .pattern(pattern),
        .cycle_sync_event(sync), .frame_valid(fv), .frame_switch_pattern(fsp),
        .frame_failsafe_release(ffr));
    fsop_port #(.DELAY_CYC(4), .LOSS_CYC(20)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .cycle_sync_event(sync), .frame_valid(fv), .frame_switch_pattern(fsp),
        .frame_failsafe_release(ffr), .acyc_wr(acyc_wr), .acyc_rd(acyc_rd),
        .acyc_addr(acyc_addr), .acyc_wdata(acyc_wdata), .acyc_rdata(acyc_rdata),
        .output_fault_status(output_fault_status), .chan_sense(chan_sense),
        .chan_overload(chan_overload), .io_supply_ok(io_supply_ok), .chan_drive(chan_drive),
        .error_event(error_event), .module_healthy_flag(module_healthy_flag),
        .logical_slots(logical_slots));
    // ----------------------------------------
    // Clock and event counting
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (error_event === 1'b1)
            n_ev++;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task final_report;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        acyc_rd <= 1'b1;
        acyc_addr <= a;
        @(posedge ref_clk);
        acyc_rd <= 1'b0;
        #1 chk(acyc_rdata, exp);
    endtask : rd
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        acyc_wr <= 1'b1;
        acyc_addr <= a;
        acyc_wdata <= d;
        @(posedge ref_clk);
        acyc_wr <= 1'b0;
    endtask : wr
    task wait_for(input int sel, input logic [7:0] exp);
        logic [7:0] v;
        for (int i = 0; i < 300; i++)
        begin
            @(posedge ref_clk);
            #1 v = (sel == 0) ? {7'h00, module_healthy_flag} :
                   (sel == 1) ? output_fault_status : {2'b00, chan_drive};
            if (v === exp)
                break;
        end
        if (v !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t wait ran out, sel %0d", $time, sel);
            final_report();
        end
        else
            chk(v, exp);
    endtask : wait_for
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        {frames_on, release_bit, acyc_wr, acyc_rd} = 4'h0;
        {pattern, acyc_addr, acyc_wdata} = 24'h000000;
        {chan_overload, sense_flip} = 12'h000;
        io_supply_ok = 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk({7'h00, module_healthy_flag}, 8'h00);
        chk({6'h00, logical_slots}, 8'h01);
        rd(REG_MODE_SELECT, MODE_RESET);
        wr(REG_STATIC_PATTERN, 8'h2A);
        rd(REG_STATIC_PATTERN, 8'h00);
        wr(REG_FAULT_STATUS, 8'hFF);
        rd(8'h50, 8'h00);
        @(posedge ref_clk);
        pattern <= 8'h15;
        release_bit <= 1'b1;
        frames_on <= 1'b1;
        wait_for(0, 8'h01);
        wait_for(2, 8'h15);
        rd(REG_STATIC_PATTERN, 8'h2A);
        wr(REG_RELEASE, 8'hFE);
        rd(REG_RELEASE, 8'h01);
        rd(REG_FAULT_STATUS, 8'h00);
        n_ev = 0;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge ref_clk);
            chan_overload <= tbl[i][0][5:0];
            sense_flip <= tbl[i][1][5:0];
            io_supply_ok <= tbl[i][2][0];
            wait_for(1, tbl[i][3]);
            @(posedge ref_clk);
            {chan_overload, sense_flip, io_supply_ok} <= 13'h0001;
            wait_for(1, 8'h00);
        end
        repeat (3) @(posedge ref_clk);
        chk(8'(n_ev), 8'h06);
        n_ev = 0;
        @(posedge ref_clk);
        pattern <= 8'hC7;
        wait_for(2, 8'h07);
        repeat (8) @(posedge ref_clk);
        chk(8'(n_ev), 8'h00);
        frames_on <= 1'b0;
        wait_for(0, 8'h00);
        wait_for(2, 8'h2A);
        rd(REG_RELEASE, 8'h00);
        @(posedge ref_clk);
        frames_on <= 1'b1;
        wait_for(0, 8'h01);
        wait_for(2, 8'h07);
        wr(REG_MODE_SELECT, MODE_RETAIN);
        rd(REG_MODE_SELECT, 8'h01);
        @(posedge ref_clk);
        frames_on <= 1'b0;
        wait_for(0, 8'h00);
        repeat (30) @(posedge ref_clk);
        #1 chk({2'b00, chan_drive}, 8'h07);
        @(posedge ref_clk);
        release_bit <= 1'b0;
        pattern <= 8'h38;
        frames_on <= 1'b1;
        repeat (40) @(posedge ref_clk);
        #1 chk({7'h00, module_healthy_flag}, 8'h00);
        chk({2'b00, chan_drive}, 8'h07);
        @(posedge ref_clk);
        release_bit <= 1'b1;
        wait_for(0, 8'h01);
        wait_for(2, 8'h38);
        @(posedge ref_clk);
        release_bit <= 1'b0;
        wait_for(0, 8'h00);
        final_report();
    end
endmodule : fsop_port_bench
